//--- core/rsse_core.sv
// Rotate, subtract-with-borrow, set and skip execution datapath with AHB-Lite registers
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module rsse_core #(
   parameter int MEM_DEPTH = 16
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   output logic             busy,
   output logic             skip_discard
);
   import rsse_pkg::*;

   logic [7:0]   mem_r [MEM_DEPTH];
   logic [7:0]   acc_r;
   rsse_flags_t  flags_r;
   rsse_cmd_t    cmd_r;
   rsse_state_t  state_r;
   logic         skip_r;
   logic         wr_pend_r;
   logic         rd_pend_r;
   logic         rd_done_r;
   logic [7:0]   addr_r;
   logic [31:0]  hrdata_r;

   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      bit_mask = 8'h01 << sel;
   endfunction

   function automatic logic is_mem_addr(input logic [7:0] a);
      is_mem_addr = (a >= OFF_MEM) && (a < OFF_MEM + 8'(MEM_DEPTH * 4));
   endfunction

   // Bus address and data phase decode
   wire         take_req  = hsel && hready && (htrans == HTRANS_NONSEQ);
   wire         idle_st   = (state_r == ST_IDLE);
   // Writes stall while an instruction runs so acc and memory never see two writers
   wire         wr_stall  = wr_pend_r && !idle_st;
   wire         rd_stall  = rd_pend_r && !rd_done_r;
   wire         wr_commit = wr_pend_r && idle_st;
   wire [3:0]   bus_midx  = 4'(addr_r[7:2] - OFF_MEM[7:2]);
   wire [7:0]   wdata8    = hwdata[7:0];

   assign hreadyout    = !(wr_stall || rd_stall);
   assign hresp        = 1'b0;
   assign hrdata       = hrdata_r;
   assign busy         = !idle_st;
   assign skip_discard = (state_r == ST_DUMMY);

   // Execution operand and results
   wire [7:0]   m_rd      = mem_r[cmd_r.addr];
   wire         exec      = (state_r == ST_EXEC);
   wire [7:0]   rl_carry  = {m_rd[6:0], flags_r.c};
   wire [7:0]   rot_plain = {m_rd[0], m_rd[7:1]};
   wire [7:0]   rot_carry = {flags_r.c, m_rd[7:1]};
   wire [7:0]   dec_res   = m_rd - 8'h01;
   wire [7:0]   inc_res   = m_rd + 8'h01;
   wire [8:0]   sub_sum   = {1'b0, acc_r} + {1'b0, ~m_rd} + {8'h00, flags_r.c};
   wire [4:0]   sub_low   = {1'b0, acc_r[3:0]} + {1'b0, ~m_rd[3:0]} + {4'h0, flags_r.c};
   wire [7:0]   sub_res   = sub_sum[7:0];
   wire         sub_ovf   = (acc_r[7] == ~m_rd[7]) && (sub_res[7] != acc_r[7]);

   logic [7:0]  acc_nxt;
   logic        acc_we;
   logic [7:0]  mem_nxt;
   logic        mem_we;
   rsse_flags_t flags_nxt;
   logic        skip_nxt;

   always_comb begin
      acc_nxt   = acc_r;
      acc_we    = 1'b0;
      mem_nxt   = m_rd;
      mem_we    = 1'b0;
      flags_nxt = flags_r;
      skip_nxt  = 1'b0;
      case (cmd_r.op)
         OP_ROTATE_LEFT_CARRY_TO_ACC: begin
            acc_nxt     = rl_carry;
            acc_we      = 1'b1;
            flags_nxt.c = m_rd[7];
         end
         OP_ROTATE_RIGHT_MEM: begin
            mem_nxt = rot_plain;
            mem_we  = 1'b1;
         end
         OP_ROTATE_RIGHT_TO_ACC: begin
            acc_nxt = rot_plain;
            acc_we  = 1'b1;
         end
         OP_ROTATE_RIGHT_CARRY_MEM: begin
            mem_nxt     = rot_carry;
            mem_we      = 1'b1;
            flags_nxt.c = m_rd[0];
         end
         OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
            acc_nxt     = rot_carry;
            acc_we      = 1'b1;
            flags_nxt.c = m_rd[0];
         end
         OP_SUBTRACT_BORROW_TO_ACC, OP_SUBTRACT_BORROW_TO_MEM: begin
            acc_nxt                  = sub_res;
            acc_we                   = (cmd_r.op == OP_SUBTRACT_BORROW_TO_ACC);
            mem_nxt                  = sub_res;
            mem_we                   = (cmd_r.op == OP_SUBTRACT_BORROW_TO_MEM);
            flags_nxt.c              = sub_sum[8];
            flags_nxt.aux_carry_flag = sub_low[4];
            flags_nxt.z              = (sub_res == 8'h00);
            flags_nxt.overflow_flag  = sub_ovf;
         end
         OP_DECREMENT_SKIP_ZERO: begin
            mem_nxt  = dec_res;
            mem_we   = 1'b1;
            skip_nxt = (dec_res == 8'h00);
         end
         OP_DECREMENT_TO_ACC_SKIP_ZERO: begin
            acc_nxt  = dec_res;
            acc_we   = 1'b1;
            skip_nxt = (dec_res == 8'h00);
         end
         OP_SET_BYTE: begin
            mem_nxt = ALL_ONES;
            mem_we  = 1'b1;
         end
         OP_SET_BIT: begin
            mem_nxt = m_rd | bit_mask(cmd_r.bitsel);
            mem_we  = 1'b1;
         end
         OP_INCREMENT_SKIP_ZERO: begin
            mem_nxt  = inc_res;
            mem_we   = 1'b1;
            skip_nxt = (inc_res == 8'h00);
         end
         OP_INCREMENT_TO_ACC_SKIP_ZERO: begin
            acc_nxt  = inc_res;
            acc_we   = 1'b1;
            skip_nxt = (inc_res == 8'h00);
         end
         OP_BIT_SET_SKIP: begin
            skip_nxt = |(m_rd & bit_mask(cmd_r.bitsel));
         end
         default: begin
            skip_nxt = 1'b0;
         end
      endcase
   end

   // Sequencer: a taken skip adds exactly one dummy cycle
   rsse_state_t state_nxt;
   always_comb begin
      case (state_r)
         ST_IDLE:  state_nxt = (wr_commit && addr_r == OFF_CMD) ? ST_EXEC : ST_IDLE;
         ST_EXEC:  state_nxt = skip_nxt ? ST_DUMMY : ST_IDLE;
         ST_DUMMY: state_nxt = ST_IDLE;
         default:  state_nxt = ST_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= ST_IDLE;
         skip_r  <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (exec) begin
            skip_r <= skip_nxt;
         end
      end
   end

   // Bus phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         rd_done_r <= 1'b0;
         addr_r    <= 8'h00;
      end else if (hreadyout) begin
         wr_pend_r <= take_req && hwrite;
         rd_pend_r <= take_req && !hwrite;
         rd_done_r <= 1'b0;
         if (take_req) begin
            addr_r <= haddr[7:0];
         end
      end else begin
         rd_done_r <= rd_pend_r;
      end
   end

   // Read data is sampled in the wait cycle so it sees any write just committed
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0000_0000;
      if (is_mem_addr(addr_r)) begin
         rd_word[7:0] = mem_r[bus_midx];
      end else begin
         case (addr_r)
            OFF_CMD:    rd_word[11:0] = {cmd_r.addr, 1'b0, cmd_r.bitsel, cmd_r.op};
            OFF_ACC:    rd_word[7:0]  = acc_r;
            OFF_FLAGS:  rd_word[3:0]  = flags_r;
            OFF_STATUS: rd_word[1:0]  = {skip_r, busy};
            default:    rd_word       = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0000_0000;
      end else if (rd_stall) begin
         hrdata_r <= rd_word;
      end
   end

   // Architectural registers: bus writes only while idle, execution only in exec
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_r   <= ACC_RST;
         flags_r <= FLAGS_RST;
         cmd_r   <= '{addr: 4'h0, bitsel: 3'h0, op: OP_ROTATE_LEFT_CARRY_TO_ACC};
      end else if (exec) begin
         flags_r <= flags_nxt;
         if (acc_we) begin
            acc_r <= acc_nxt;
         end
      end else if (wr_commit) begin
         case (addr_r)
            OFF_CMD: begin
               cmd_r.op     <= rsse_op_t'(hwdata[CMD_OP_LSB +: 4]);
               cmd_r.bitsel <= hwdata[CMD_BIT_LSB +: 3];
               cmd_r.addr   <= hwdata[CMD_ADDR_LSB +: 4];
            end
            OFF_ACC:   acc_r   <= wdata8;
            OFF_FLAGS: flags_r <= hwdata[3:0];
            default:   acc_r   <= acc_r;
         endcase
      end
   end

   // Data memory keeps no reset; software initialises it
   always_ff @(posedge hclk) begin
      if (exec && mem_we) begin
         mem_r[cmd_r.addr] <= mem_nxt;
      end else if (wr_commit && is_mem_addr(addr_r)) begin
         mem_r[bus_midx] <= wdata8;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_rot_left_carry;
      exec && cmd_r.op == OP_ROTATE_LEFT_CARRY_TO_ACC |=>
         acc_r == {$past(m_rd[6:0]), $past(flags_r.c)} && flags_r.c == $past(m_rd[7]);
   endproperty
   a_rot_left_carry: assert property (p_rot_left_carry) else $error("left rotate through carry wrong");

   property p_rot_right_mem;
      exec && cmd_r.op == OP_ROTATE_RIGHT_MEM |=>
         mem_r[$past(cmd_r.addr)] == {$past(m_rd[0]), $past(m_rd[7:1])} && $stable(flags_r);
   endproperty
   a_rot_right_mem: assert property (p_rot_right_mem) else $error("right rotate of memory wrong");

   property p_rot_right_acc;
      exec && cmd_r.op == OP_ROTATE_RIGHT_TO_ACC |=>
         acc_r == {$past(m_rd[0]), $past(m_rd[7:1])} && $stable(flags_r) && $stable(m_rd);
   endproperty
   a_rot_right_acc: assert property (p_rot_right_acc) else $error("right rotate into acc wrong");

   property p_rot_right_carry;
      exec && (cmd_r.op == OP_ROTATE_RIGHT_CARRY_MEM || cmd_r.op == OP_ROTATE_RIGHT_CARRY_TO_ACC) |=>
         flags_r.c == $past(m_rd[0]) && flags_r[3:1] == $past(flags_r[3:1]);
   endproperty
   a_rot_right_carry: assert property (p_rot_right_carry) else $error("carry after right rotate wrong");

   property p_sub_borrow;
      exec && cmd_r.op == OP_SUBTRACT_BORROW_TO_ACC |=>
         acc_r == 8'($past(acc_r) - $past(m_rd) - 8'(!$past(flags_r.c))) && flags_r.z == (acc_r == 8'h00);
   endproperty
   a_sub_borrow: assert property (p_sub_borrow) else $error("subtract with borrow wrong");

   property p_dec_skip;
      exec && cmd_r.op == OP_DECREMENT_SKIP_ZERO && m_rd == 8'h01 |=>
         state_r == ST_DUMMY ##1 state_r == ST_IDLE && mem_r[cmd_r.addr] == 8'h00;
   endproperty
   a_dec_skip: assert property (p_dec_skip) else $error("decrement skip not taken");

   property p_inc_wrap;
      exec && cmd_r.op == OP_INCREMENT_TO_ACC_SKIP_ZERO && m_rd == 8'hff |=>
         acc_r == 8'h00 && skip_discard && $stable(flags_r);
   endproperty
   a_inc_wrap: assert property (p_inc_wrap) else $error("increment wrap skip wrong");

   property p_set_bit;
      exec && cmd_r.op == OP_SET_BIT |=>
         mem_r[$past(cmd_r.addr)] == ($past(m_rd) | (8'h01 << $past(cmd_r.bitsel)));
   endproperty
   a_set_bit: assert property (p_set_bit) else $error("bit set wrong");

   property p_bit_skip;
      exec && cmd_r.op == OP_BIT_SET_SKIP |=>
         skip_discard == $past(m_rd[cmd_r.bitsel]) && $stable(flags_r);
   endproperty
   a_bit_skip: assert property (p_bit_skip) else $error("bit skip decision wrong");

   property p_no_skip;
      exec && !skip_nxt |=> idle_st;
   endproperty
   a_no_skip: assert property (p_no_skip) else $error("dummy cycle without skip");

   property p_set_byte;
      exec && cmd_r.op == OP_SET_BYTE |=>
         mem_r[$past(cmd_r.addr)] == ALL_ONES && $stable(flags_r);
   endproperty
   a_set_byte: assert property (p_set_byte) else $error("byte set wrong");

   property p_inc_skip;
      exec && cmd_r.op == OP_INCREMENT_SKIP_ZERO |=>
         mem_r[$past(cmd_r.addr)] == 8'($past(m_rd) + 8'h01) && skip_discard == ($past(m_rd) == 8'hff)
         && $stable(flags_r);
   endproperty
   a_inc_skip: assert property (p_inc_skip) else $error("increment skip wrong");
endmodule
`default_nettype wire

//--- inc/rsse_pkg.sv
// Package for the rotate, subtract and skip execution datapath
package rsse_pkg;
   localparam int DATA_W = 8;
   // Register byte offsets
   localparam logic [7:0] OFF_CMD    = 8'h00;
   localparam logic [7:0] OFF_ACC    = 8'h04;
   localparam logic [7:0] OFF_FLAGS  = 8'h08;
   localparam logic [7:0] OFF_STATUS = 8'h0c;
   localparam logic [7:0] OFF_MEM    = 8'h40;
   // Command field positions
   localparam int CMD_OP_LSB   = 0;
   localparam int CMD_BIT_LSB  = 4;
   localparam int CMD_ADDR_LSB = 8;
   // Flag and status bit positions
   localparam int FLG_C  = 0;
   localparam int FLG_AUX_CARRY = 1;
   localparam int FLG_Z  = 2;
   localparam int FLG_OVERFLOW = 3;
   localparam int ST_BUSY = 0;
   localparam int ST_SKIP = 1;
   // Reset values and other constants
   localparam logic [7:0] ACC_RST   = 8'h00;
   localparam logic [3:0] FLAGS_RST = 4'h0;
   localparam logic [7:0] ALL_ONES  = 8'hff;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   // Dummy cycles inserted after a taken skip
   localparam int SKIP_DUMMY_CYC = 1;

   typedef enum logic [3:0] {
      OP_ROTATE_LEFT_CARRY_TO_ACC   = 4'h0,
      OP_ROTATE_RIGHT_MEM           = 4'h1,
      OP_ROTATE_RIGHT_TO_ACC        = 4'h2,
      OP_ROTATE_RIGHT_CARRY_MEM     = 4'h3,
      OP_ROTATE_RIGHT_CARRY_TO_ACC  = 4'h4,
      OP_SUBTRACT_BORROW_TO_ACC     = 4'h5,
      OP_SUBTRACT_BORROW_TO_MEM     = 4'h6,
      OP_DECREMENT_SKIP_ZERO        = 4'h7,
      OP_DECREMENT_TO_ACC_SKIP_ZERO = 4'h8,
      OP_SET_BYTE                   = 4'h9,
      OP_SET_BIT                    = 4'ha,
      OP_INCREMENT_SKIP_ZERO        = 4'hb,
      OP_INCREMENT_TO_ACC_SKIP_ZERO = 4'hc,
      OP_BIT_SET_SKIP               = 4'hd
   } rsse_op_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_EXEC  = 3'b010,
      ST_DUMMY = 3'b100
   } rsse_state_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [2:0] bitsel;
      rsse_op_t   op;
   } rsse_cmd_t;

   typedef struct packed {
      logic overflow_flag;
      logic z;
      logic aux_carry_flag;
      logic c;
   } rsse_flags_t;
endpackage

//--- testbench/rsse_ahb_master.sv
// AHB-Lite single-transfer master standing in for the core that issues instructions
`timescale 1ns/1ps
`default_nettype none
module rsse_ahb_master (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata
);
   import rsse_pkg::*;
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   // Call just after a rising edge; no idle edge, so a write can meet a running instruction
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
endmodule
`default_nettype wire

//--- testbench/test_rotate_subtract_skip_exec.sv
// Self-checking bench for the rotate, subtract and skip datapath
`timescale 1ns/1ps
`default_nettype none
`define CHECK(act_v, exp_v) begin comparisons++; if ((act_v) !== (exp_v)) begin fails++; \
   $display("wrong value at %0t: got %h expected %h", $time, act_v, exp_v); end end
module test_rotate_subtract_skip_exec;
   import rsse_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic        hwrite;
   logic        hreadyout;
   logic        hresp;
   logic        busy;
   logic        skip_discard;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          fails;
   int          comparisons;
   int          busy_cyc;
   int          skip_cyc;
   int          stall_cyc;

   initial hclk = 1'b0;
   always #50 hclk = ~hclk;

   rsse_core u_dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .busy(busy),
      .skip_discard(skip_discard)
   );
   rsse_ahb_master u_mst (
      .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
   );

   // Counts execution and dummy cycles of the instruction in flight, and bus wait states
   always @(posedge hclk) begin
      if (busy === 1'b1) busy_cyc++;
      if (skip_discard === 1'b1) skip_cyc++;
      if (hreadyout === 1'b0) stall_cyc++;
   end

   task automatic finish_test;
      if (fails == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      u_mst.xfer(1'b1, a, d, x);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      u_mst.xfer(1'b0, a, 32'h0, d);
   endtask

   task automatic reset_values;
      logic [31:0] d;
      rd(OFF_ACC, d);
      `CHECK(d, {24'h0, ACC_RST})
      rd(OFF_FLAGS, d);
      `CHECK(d, {28'h0, FLAGS_RST})
      rd(OFF_STATUS, d);
      `CHECK(d, 32'h0)
      // Unmapped place reads zero and ignores writes
      wr(8'h20, 32'hdeadbeef);
      rd(8'h20, d);
      `CHECK(d, 32'h0)
      `CHECK(hresp, 1'b0)
   endtask

   // Loads operands, executes one command and judges every visible result
   task automatic run(input logic [3:0] op, input logic [2:0] b, input logic [3:0] ad,
                      input logic [7:0] m, input logic [7:0] a, input logic [3:0] f,
                      input logic [7:0] em, input logic [7:0] ea, input logic [3:0] ef,
                      input logic es);
      logic [31:0] d;
      logic [7:0]  ma;
      ma = OFF_MEM + {2'b00, ad, 2'b00};
      wr(ma, {24'h0, m});
      wr(OFF_ACC, {24'h0, a});
      wr(OFF_FLAGS, {28'h0, f});
      busy_cyc = 0;
      skip_cyc = 0;
      wr(OFF_CMD, {20'h0, ad, 1'b0, b, op});
      do rd(OFF_STATUS, d); while (d[ST_BUSY] !== 1'b0);
      `CHECK(d[ST_SKIP], es)
      `CHECK(busy_cyc, 1 + SKIP_DUMMY_CYC * es)
      `CHECK(skip_cyc, SKIP_DUMMY_CYC * es)
      rd(ma, d);
      `CHECK(d[7:0], em)
      rd(OFF_ACC, d);
      `CHECK(d[7:0], ea)
      rd(OFF_FLAGS, d);
      `CHECK(d[3:0], ef)
   endtask

   task automatic test_rotates;
      run(4'h0, 3'h0, 4'h1, 8'h81, 8'h00, 4'he, 8'h81, 8'h02, 4'hf, 1'b0);
      run(4'h1, 3'h0, 4'h2, 8'h01, 8'h33, 4'h5, 8'h80, 8'h33, 4'h5, 1'b0);
      run(4'h2, 3'h0, 4'h3, 8'h03, 8'h00, 4'ha, 8'h03, 8'h81, 4'ha, 1'b0);
      run(4'h3, 3'h0, 4'h4, 8'h02, 8'h00, 4'hf, 8'h81, 8'h00, 4'he, 1'b0);
      run(4'h4, 3'h0, 4'h5, 8'h01, 8'h55, 4'h0, 8'h01, 8'h00, 4'h1, 1'b0);
   endtask

   task automatic test_subtract;
      run(4'h5, 3'h0, 4'h6, 8'h05, 8'h05, 4'h1, 8'h05, 8'h00, 4'h7, 1'b0);
      run(4'h5, 3'h0, 4'h7, 8'h00, 8'h00, 4'he, 8'h00, 8'hff, 4'h0, 1'b0);
      run(4'h6, 3'h0, 4'h8, 8'h01, 8'h80, 4'h1, 8'h7f, 8'h80, 4'h9, 1'b0);
   endtask

   task automatic test_count_skips;
      run(4'h7, 3'h0, 4'h9, 8'h01, 8'h3c, 4'h5, 8'h00, 8'h3c, 4'h5, 1'b1);
      run(4'h7, 3'h0, 4'ha, 8'h00, 8'h3c, 4'ha, 8'hff, 8'h3c, 4'ha, 1'b0);
      run(4'h8, 3'h0, 4'hb, 8'h01, 8'h77, 4'h6, 8'h01, 8'h00, 4'h6, 1'b1);
      run(4'h8, 3'h0, 4'hc, 8'h05, 8'h00, 4'h9, 8'h05, 8'h04, 4'h9, 1'b0);
      run(4'hb, 3'h0, 4'h0, 8'hff, 8'h22, 4'h3, 8'h00, 8'h22, 4'h3, 1'b1);
      run(4'hb, 3'h0, 4'h1, 8'h7f, 8'h22, 4'hc, 8'h80, 8'h22, 4'hc, 1'b0);
      run(4'hc, 3'h0, 4'h2, 8'hff, 8'h11, 4'ha, 8'hff, 8'h00, 4'ha, 1'b1);
      run(4'hc, 3'h0, 4'h3, 8'h0f, 8'h00, 4'h5, 8'h0f, 8'h10, 4'h5, 1'b0);
   endtask

   task automatic test_sets_and_bit_skip;
      run(4'h9, 3'h0, 4'hd, 8'h12, 8'h00, 4'h3, 8'hff, 8'h00, 4'h3, 1'b0);
      run(4'ha, 3'h7, 4'he, 8'h00, 8'h00, 4'hc, 8'h80, 8'h00, 4'hc, 1'b0);
      run(4'ha, 3'h3, 4'hf, 8'hf0, 8'h00, 4'h5, 8'hf8, 8'h00, 4'h5, 1'b0);
      run(4'hd, 3'h2, 4'h4, 8'h04, 8'h00, 4'h6, 8'h04, 8'h00, 4'h6, 1'b1);
      run(4'hd, 3'h0, 4'h5, 8'hfe, 8'h00, 4'h9, 8'hfe, 8'h00, 4'h9, 1'b0);
      run(4'he, 3'h0, 4'h6, 8'h5a, 8'ha5, 4'h6, 8'h5a, 8'ha5, 4'h6, 1'b0);
   endtask

   // A write that meets a taken skip waits out the dummy cycle, then lands over the result
   task automatic test_write_stall;
      logic [31:0] d;
      wr(OFF_MEM, 32'h0000_00ff);
      wr(OFF_CMD, {20'h0, 4'h0, 1'b0, 3'h0, OP_INCREMENT_TO_ACC_SKIP_ZERO});
      stall_cyc = 0;
      wr(OFF_ACC, 32'h0000_005a);
      `CHECK(stall_cyc, SKIP_DUMMY_CYC)
      rd(OFF_ACC, d);
      `CHECK(d[7:0], 8'h5a)
      rd(OFF_STATUS, d);
      `CHECK(d[1:0], 2'b10)
   endtask

   initial begin
      fails = 0;
      comparisons = 0;
      busy_cyc = 0;
      skip_cyc = 0;
      stall_cyc = 0;
      hresetn = 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      reset_values();
      test_rotates();
      test_subtract();
      test_count_skips();
      test_sets_and_bit_skip();
      test_write_stall();
      finish_test();
   end

   // Whole sequence needs about five hundred cycles; this allows twenty times that
   initial begin
      #1_000_000;
      fails++;
      finish_test();
   end
endmodule
`default_nettype wire
